// *** rtl/sdct_pkg.sv ***
// Constants shared by the SDRAM controller end and the memory end.
// Assumes one 40 MHz clock shared by both ends and a synchronous reset.
package sdct_pkg;
  localparam int AW          = 12;
  localparam int DW          = 16;
  localparam int MW          = 2;
  localparam int CW          = 8;
  localparam int CLK_NS      = 25;
  localparam int PALL_BIT    = 10;
  localparam int MR_BL_LSB   = 0;
  localparam int MR_BT_BIT   = 3;
  localparam int MR_CL_LSB   = 4;
  localparam logic [2:0] BL_1    = 3'h0;
  localparam logic [2:0] BL_PAGE = 3'h7;
  localparam logic [2:0] CL_2    = 3'h2;
  localparam logic [2:0] CL_3    = 3'h3;
  localparam int T_RRD_NS    = 15;
  localparam int T_RCD_NS    = 20;
  localparam int T_RP_NS     = 20;
  localparam int T_RAS_NS    = 45;
  localparam int T_RC_NS     = 65;
  localparam int MODE_GAP    = 2;
  localparam int WR_REC_CLK  = 2;
  // Cycles for a minimum time, rounded up.
  function automatic int cyc(input int ns);
    return (ns + CLK_NS - 1) / CLK_NS;
  endfunction
  function automatic int maxi(input int a, input int b);
    return (a > b) ? a : b;
  endfunction
  localparam int RRD_CYC = cyc(T_RRD_NS);
  localparam int RCD_CYC = cyc(T_RCD_NS);
  localparam int RP_CYC  = cyc(T_RP_NS);
  localparam int RAS_CYC = cyc(T_RAS_NS);
  localparam int RC_CYC  = cyc(T_RC_NS);
  localparam int DAL_CYC = WR_REC_CLK + RP_CYC;
  // Command code is {cs_n, ras_n, cas_n, we_n}.
  typedef enum logic [3:0] {
    CMD_MODE = 4'h0,
    CMD_REF  = 4'h1,
    CMD_PRE  = 4'h2,
    CMD_ACT  = 4'h3,
    CMD_WR   = 4'h4,
    CMD_RD   = 4'h5,
    CMD_STOP = 4'h6,
    CMD_NOP  = 4'h7
  } sdct_cmd_e;
endpackage

// *** rtl/sdct_if.sv ***
// Link between the controller end and the memory end.
// Assumes both ends run on the clock given to this interface.
`timescale 1ns/1ps
`default_nettype none
interface sdct_if
  import sdct_pkg::*;
(
  input wire logic clock
);
  logic          cs_n;
  logic          ras_n;
  logic          cas_n;
  logic          we_n;
  logic [1:0]    bank_select;
  logic [AW-1:0] addr;
  logic [MW-1:0] dqm;
  logic [DW-1:0] dq_ctl_o;
  logic          dq_ctl_oe;
  logic [DW-1:0] dq_mem_o;
  logic          dq_mem_oe;
  logic [DW-1:0] dq;
  // Resolves the shared data wire from both enables.
  assign dq = dq_mem_oe ? dq_mem_o : (dq_ctl_oe ? dq_ctl_o : '0);
  modport ctl (
    output cs_n, ras_n, cas_n, we_n, bank_select, addr, dqm,
    output dq_ctl_o, dq_ctl_oe,
    input  dq
  );
  modport mem (
    input  cs_n, ras_n, cas_n, we_n, bank_select, addr, dqm,
    output dq_mem_o, dq_mem_oe,
    input  dq
  );
endinterface
`default_nettype wire

// *** rtl/sdct_mem.sv ***
// Memory end: command decoder, bank state, bursts and a small array.
// Assumes the controller keeps the command spacing rules.
`timescale 1ns/1ps
`default_nettype none
module sdct_mem
  import sdct_pkg::*;
#(
  parameter int IDX_W = 2
) (
  input wire logic clock,
  input wire logic rstn,
  sdct_if.mem      lnk
);
  localparam int DEPTH = 4 << IDX_W;
  sdct_cmd_e         cmd;
  logic [DW-1:0]     mem [DEPTH];
  logic [2:0]        cl;
  logic [2:0]        bl;
  logic              bt;
  logic [3:0]        bank_open;
  logic              bu_on;
  logic              bu_wr;
  logic              bu_ap;
  logic [1:0]        bu_bank;
  logic [CW-1:0]     bu_col;
  logic [CW:0]       bu_cnt;
  logic              col_go;
  logic              cut;
  logic              beat;
  logic              wr;
  logic              ap;
  logic [1:0]        bank;
  logic [CW-1:0]     base;
  logic [CW-1:0]     k;
  logic [CW-1:0]     mask;
  logic [CW-1:0]     col;
  logic [CW:0]       len;
  logic [CW:0]       next_cnt;
  logic              last;
  logic [IDX_W+1:0]  idx;
  logic [2:0]        pv;
  logic [DW-1:0]     pd [3];
  logic [MW-1:0]     dqm_q1;
  logic [MW-1:0]     dqm_q2;

  ////////////////////////////////////////////////////////////////////
  // Decode and burst addressing.
  always_comb begin
    cmd = lnk.cs_n ? CMD_NOP
                   : sdct_cmd_e'({1'b0, lnk.ras_n, lnk.cas_n, lnk.we_n});
    col_go = (cmd == CMD_RD) || (cmd == CMD_WR);
    cut = (cmd == CMD_STOP) || (cmd == CMD_PRE);
    beat = col_go || (bu_on && !cut);
    wr = col_go ? (cmd == CMD_WR) : bu_wr;
    ap = col_go ? lnk.addr[PALL_BIT] : bu_ap;
    bank = col_go ? lnk.bank_select : bu_bank;
    base = col_go ? lnk.addr[CW-1:0] : bu_col;
    k = col_go ? '0 : bu_cnt[CW-1:0];
    case (bl)
      3'h0: len = (CW+1)'(1);
      3'h1: len = (CW+1)'(2);
      3'h2: len = (CW+1)'(4);
      3'h3: len = (CW+1)'(8);
      default: len = (CW+1)'(1 << CW);
    endcase
    mask = CW'(len - 1'b1);
    col = (base & ~mask) | ((bt ? (base ^ k) : CW'(base + k)) & mask);
    next_cnt = (CW+1)'({1'b0, k} + 1'b1);
    last = (next_cnt == len);
    idx = {bank, col[IDX_W-1:0]};
  end

  ////////////////////////////////////////////////////////////////////
  // Mode key.
  always_ff @(posedge clock) begin
    if (!rstn) begin
      cl <= CL_3;
      bl <= BL_1;
      bt <= 1'b0;
    end else if (cmd == CMD_MODE) begin
      cl <= lnk.addr[MR_CL_LSB +: 3];
      bl <= lnk.addr[MR_BL_LSB +: 3];
      bt <= lnk.addr[MR_BT_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Bank state.
  always_ff @(posedge clock) begin
    if (!rstn) begin
      bank_open <= 4'h0;
    end else if (cmd == CMD_REF) begin
      bank_open <= 4'h0;
    end else if (cmd == CMD_PRE && lnk.addr[PALL_BIT]) begin
      bank_open <= 4'h0;
    end else if (cmd == CMD_PRE) begin
      bank_open[lnk.bank_select] <= 1'b0;
    end else if (cmd == CMD_ACT) begin
      bank_open[lnk.bank_select] <= 1'b1;
    end else if (beat && last && ap) begin
      bank_open[bank] <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Burst tracking.
  always_ff @(posedge clock) begin
    if (!rstn) begin
      bu_on <= 1'b0;
      bu_wr <= 1'b0;
      bu_ap <= 1'b0;
      bu_bank <= 2'h0;
      bu_col <= '0;
      bu_cnt <= '0;
    end else begin
      bu_on <= beat && !last;
      bu_wr <= wr;
      bu_ap <= ap;
      bu_bank <= bank;
      bu_col <= base;
      bu_cnt <= next_cnt;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Array write with zero-latency byte mask.
  always_ff @(posedge clock) begin
    for (int b = 0; b < MW; b++) begin
      if (beat && wr && bank_open[bank] && !lnk.dqm[b]) begin
        mem[idx][b*8 +: 8] <= lnk.dq[b*8 +: 8];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Read pipe; words in flight finish after a cut.
  always_ff @(posedge clock) begin
    if (!rstn) begin
      pv <= 3'h0;
      dqm_q1 <= '0;
      dqm_q2 <= '0;
    end else begin
      pv <= {pv[1:0], beat && !wr};
      dqm_q1 <= lnk.dqm;
      dqm_q2 <= dqm_q1;
    end
  end

  always_ff @(posedge clock) begin
    pd[0] <= mem[idx];
    pd[1] <= pd[0];
    pd[2] <= pd[1];
  end

  always_comb begin
    lnk.dq_mem_o = (cl == CL_2) ? pd[1] : pd[2];
    lnk.dq_mem_oe = ((cl == CL_2) ? pv[1] : pv[2]) && !dqm_q2[0];
  end
endmodule
`default_nettype wire

// *** rtl/sdct_ctl.sv ***
// Controller end: initialises the memory, then serves single-word
// reads and writes with auto precharge, and refresh on request.
// Assumes the memory end shares the clock and decodes the link.
`timescale 1ns/1ps
`default_nettype none
module sdct_ctl
  import sdct_pkg::*;
#(
  parameter int CAS_LAT = 3
) (
  input  wire logic          clock,
  input  wire logic          rstn,
  input  wire logic          req_valid,
  output logic               req_ready,
  input  wire logic          req_write,
  input  wire logic [1:0]    req_bank,
  input  wire logic [AW-1:0] req_row,
  input  wire logic [CW-1:0] req_col,
  input  wire logic [DW-1:0] req_wdata,
  input  wire logic [MW-1:0] req_mask,
  input  wire logic          ref_req,
  output logic               ref_pend,
  output logic               init_done,
  output logic               rd_valid,
  output logic [DW-1:0]      rd_data,
  sdct_if.ctl                lnk
);
  // Gaps are command-to-command cycles.
  localparam int GAP_RD = maxi(maxi(CAS_LAT + 1, RC_CYC - RCD_CYC),
                               RAS_CYC - RCD_CYC + RP_CYC);
  localparam int GAP_WR = maxi(maxi(DAL_CYC, RC_CYC - RCD_CYC),
                               RAS_CYC - RCD_CYC + RP_CYC);
  localparam int GAP_MAX = maxi(maxi(GAP_RD, GAP_WR),
                                maxi(RC_CYC, maxi(RRD_CYC, MODE_GAP)));
  localparam int WTW = $clog2(GAP_MAX + 1);

  typedef enum logic [4:0] {
    ST_PALL = 5'b00001,
    ST_MODE = 5'b00010,
    ST_IDLE = 5'b00100,
    ST_COL  = 5'b01000,
    ST_REC  = 5'b10000
  } sdct_state_e;

  sdct_state_e     state;
  sdct_cmd_e       cmd;
  logic [WTW-1:0]  wait_cnt;
  logic            wait_done;
  logic            take;
  logic            r_write;
  logic [1:0]      r_bank;
  logic [CW-1:0]   r_col;
  logic [DW-1:0]   r_wdata;
  logic [MW-1:0]   r_mask;
  logic [CAS_LAT:0] rd_sh;

  ////////////////////////////////////////////////////////////////////
  // Request acceptance.
  always_comb begin
    wait_done = (wait_cnt == '0);
    req_ready = (state == ST_IDLE) && wait_done && !ref_pend && !ref_req;
    take = req_ready && req_valid;
  end

  ////////////////////////////////////////////////////////////////////
  // Refresh request; a new request wins over the clear.
  always_ff @(posedge clock) begin
    if (!rstn) begin
      ref_pend <= 1'b0;
    end else if (ref_req) begin
      ref_pend <= 1'b1;
    end else if (state == ST_IDLE && wait_done) begin
      ref_pend <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Sequencer and command issue.
  always_ff @(posedge clock) begin
    if (!rstn) begin
      state <= ST_PALL;
      cmd <= CMD_NOP;
      wait_cnt <= '0;
      init_done <= 1'b0;
      lnk.bank_select <= 2'h0;
      lnk.addr <= '0;
      lnk.dqm <= '0;
      lnk.dq_ctl_o <= '0;
      lnk.dq_ctl_oe <= 1'b0;
    end else begin
      cmd <= CMD_NOP;
      lnk.dq_ctl_oe <= 1'b0;
      lnk.dqm <= '0;
      if (!wait_done) begin
        wait_cnt <= wait_cnt - 1'b1;
      end else begin
        case (state)
          ST_PALL: begin
            cmd <= CMD_PRE;
            lnk.addr <= '0;
            lnk.addr[PALL_BIT] <= 1'b1;
            wait_cnt <= WTW'(RP_CYC - 1);
            state <= ST_MODE;
          end
          ST_MODE: begin
            cmd <= CMD_MODE;
            lnk.bank_select <= 2'h0;
            lnk.addr <= '0;
            lnk.addr[MR_CL_LSB +: 3] <= 3'(CAS_LAT);
            lnk.addr[MR_BL_LSB +: 3] <= BL_1;
            wait_cnt <= WTW'(MODE_GAP - 1);
            state <= ST_IDLE;
          end
          ST_IDLE: begin
            init_done <= 1'b1;
            if (ref_pend || ref_req) begin
              cmd <= CMD_REF;
              wait_cnt <= WTW'(RC_CYC - 1);
            end else if (req_valid) begin
              cmd <= CMD_ACT;
              lnk.bank_select <= req_bank;
              lnk.addr <= req_row;
              wait_cnt <= WTW'(RCD_CYC - 1);
              state <= ST_COL;
            end
          end
          ST_COL: begin
            cmd <= r_write ? CMD_WR : CMD_RD;
            lnk.bank_select <= r_bank;
            lnk.addr <= '0;
            lnk.addr[CW-1:0] <= r_col;
            lnk.addr[PALL_BIT] <= 1'b1;
            lnk.dq_ctl_o <= r_wdata;
            lnk.dq_ctl_oe <= r_write;
            lnk.dqm <= r_write ? r_mask : '0;
            // Next command waits out the whole auto-precharge burst.
            wait_cnt <= WTW'((r_write ? GAP_WR : GAP_RD) - 1);
            state <= ST_REC;
          end
          ST_REC: begin
            state <= ST_IDLE;
          end
          default: begin
            state <= ST_PALL;
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Request hold.
  always_ff @(posedge clock) begin
    if (!rstn) begin
      r_write <= 1'b0;
      r_bank <= 2'h0;
      r_col <= '0;
      r_wdata <= '0;
      r_mask <= '0;
    end else if (take) begin
      r_write <= req_write;
      r_bank <= req_bank;
      r_col <= req_col;
      r_wdata <= req_wdata;
      r_mask <= req_mask;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Read data capture at the read latency.
  always_ff @(posedge clock) begin
    if (!rstn) begin
      rd_sh <= '0;
      rd_valid <= 1'b0;
      rd_data <= '0;
    end else begin
      rd_sh <= {rd_sh[CAS_LAT-1:0], state == ST_COL && wait_done && !r_write};
      rd_valid <= rd_sh[CAS_LAT];
      if (rd_sh[CAS_LAT]) begin
        rd_data <= lnk.dq;
      end
    end
  end

  always_comb begin
    lnk.cs_n = 1'b0;
    {lnk.ras_n, lnk.cas_n, lnk.we_n} = cmd[2:0];
  end
endmodule
`default_nettype wire

// *** verification/sdct_props.sv ***
// Concurrent checks on the link between the controller end and the memory end.
// Assumes the testbench feeds it the link signals and the synchronous reset.
`timescale 1ns/1ps
`default_nettype none
module sdct_props
  import sdct_pkg::*;
(
  input wire logic          clock,
  input wire logic          rstn,
  input wire logic          cs_n,
  input wire logic          ras_n,
  input wire logic          cas_n,
  input wire logic          we_n,
  input wire logic [1:0]    bank_select,
  input wire logic [AW-1:0] addr,
  input wire logic [MW-1:0] dqm,
  input wire logic          dq_ctl_oe,
  input wire logic          dq_mem_oe
);
  logic [3:0] cmd;
  logic       open_any;
  assign cmd = {cs_n, ras_n, cas_n, we_n};
  ////////////////////////////////////////////////////////////////////////////////
  // Tracks whether any row may still be open.
  always_ff @(posedge clock) begin
    if (!rstn) begin
      open_any <= 1'b0;
    end else if (cmd == CMD_ACT) begin
      open_any <= 1'b1;
    end else if ((cmd == CMD_PRE || cmd == CMD_RD || cmd == CMD_WR) && addr[PALL_BIT]) begin
      open_any <= 1'b0;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rstn);
  a_mode_gap: assert property (cmd == CMD_MODE |=> cmd == CMD_NOP)
    else $error("command inside the mode gap");
  a_mode_idle: assert property (cmd == CMD_MODE |-> !open_any)
    else $error("mode program with a row open");
  a_refresh_idle: assert property (cmd == CMD_REF |-> !open_any)
    else $error("refresh with a row open");
  a_write_data_same: assert property (cmd == CMD_WR |-> dq_ctl_oe && !dq_mem_oe)
    else $error("write data not on the write edge");
  a_read_mask_off: assert property (dqm[0] |-> ##2 !dq_mem_oe)
    else $error("masked read still drives data");
  a_read_latency: assert property ((cmd == CMD_RD) ##1 !dqm[0] |-> ##2 dq_mem_oe)
    else $error("read data missing at read latency");
  a_read_source: assert property (dq_mem_oe |-> $past(cmd, 3) == CMD_RD)
    else $error("memory drives data without a read");
  a_act_cycle: assert property (cmd == CMD_ACT |=> (cmd != CMD_ACT) [*2])
    else $error("activates closer than row cycle time");
  a_write_recovery: assert property (cmd == CMD_WR |=> (cmd != CMD_ACT) [*2])
    else $error("activate too soon after write");
  a_col_after_act: assert property ((cmd == CMD_RD || cmd == CMD_WR) |-> $past(cmd) == CMD_ACT)
    else $error("column command without activate");
  a_bank_kept: assert property ((cmd == CMD_ACT) ##1 (cmd == CMD_RD || cmd == CMD_WR)
    |-> bank_select == $past(bank_select))
    else $error("column bank differs from activated bank");
  c_refresh: cover property (cmd == CMD_REF);
  c_write: cover property (cmd == CMD_WR);
  c_read: cover property ((cmd == CMD_RD) ##3 dq_mem_oe);
endmodule
`default_nettype wire

// *** verification/sdct_tb.sv ***
// Self-checking testbench joining the controller end and the memory end.
// Assumes a 40 MHz clock and the request timing of the controller user side.
`timescale 1ns/1ps
`default_nettype none
module sdct_tb
  import sdct_pkg::*;
;
  localparam int CAS_LAT = 3;
  logic          clock;
  logic          rstn;
  logic          req_valid;
  logic          req_ready;
  logic          req_write;
  logic [1:0]    req_bank;
  logic [AW-1:0] req_row;
  logic [CW-1:0] req_col;
  logic [DW-1:0] req_wdata;
  logic [MW-1:0] req_mask;
  logic          ref_req;
  logic          ref_pend;
  logic          init_done;
  logic          rd_valid;
  logic [DW-1:0] rd_data;
  logic [3:0]    wcmd;
  logic [DW-1:0] model [16];
  int            n_mismatch;
  int            cmp_count;
  int            i;
  ////////////////////////////////////////////////////////////////////////////////
  sdct_if link (.clock(clock));
  sdct_ctl #(.CAS_LAT(CAS_LAT)) sdct_ctl_inst (
    .clock(clock), .rstn(rstn), .req_valid(req_valid), .req_ready(req_ready),
    .req_write(req_write), .req_bank(req_bank), .req_row(req_row), .req_col(req_col),
    .req_wdata(req_wdata), .req_mask(req_mask), .ref_req(ref_req), .ref_pend(ref_pend),
    .init_done(init_done), .rd_valid(rd_valid), .rd_data(rd_data), .lnk(link));
  sdct_mem sdct_mem_inst (.clock(clock), .rstn(rstn), .lnk(link));
  sdct_props sdct_props_inst (
    .clock(clock), .rstn(rstn), .cs_n(link.cs_n), .ras_n(link.ras_n), .cas_n(link.cas_n),
    .we_n(link.we_n), .bank_select(link.bank_select), .addr(link.addr), .dqm(link.dqm),
    .dq_ctl_oe(link.dq_ctl_oe), .dq_mem_oe(link.dq_mem_oe));
  assign wcmd = {link.cs_n, link.ras_n, link.cas_n, link.we_n};
  initial clock = 1'b0;
  always #12.5 clock = ~clock;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic test_done();
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // One request, checked on the link and against the local word model.
  task automatic access(input logic wr, input logic [1:0] b, input logic [AW-1:0] row,
                        input logic [CW-1:0] col, input logic [DW-1:0] d,
                        input logic [MW-1:0] m);
    int         n;
    logic [3:0] idx;
    idx = {b, col[1:0]};
    @(posedge clock);
    req_valid <= 1'b1;
    req_write <= wr;
    req_bank <= b;
    req_row <= row;
    req_col <= col;
    req_wdata <= d;
    req_mask <= m;
    n = 0;
    do begin
      @(negedge clock);
      n++;
    end while (req_ready !== 1'b1 && n < 200);
    if (n >= 200) n_mismatch++;
    @(posedge clock);
    req_valid <= 1'b0;
    #1;
    check("act cmd", wcmd, CMD_ACT);
    check("act bank", link.bank_select, b);
    check("act row", link.addr, row);
    @(posedge clock);
    #1;
    check("col cmd", wcmd, wr ? CMD_WR : CMD_RD);
    check("col addr", {link.addr[PALL_BIT], link.addr[CW-1:0]}, {1'b1, col});
    check("col bank", link.bank_select, b);
    if (wr) begin
      check("wr data", link.dq, d);
      check("wr mask", link.dqm, m);
      if (!m[0]) model[idx][7:0] = d[7:0];
      if (!m[1]) model[idx][15:8] = d[15:8];
    end else begin
      repeat (CAS_LAT + 1) @(posedge clock);
      #1;
      check("rd valid", rd_valid, 1'b1);
      check("rd data", rd_data, model[idx]);
      @(posedge clock);
      #1;
      check("rd pulse", rd_valid, 1'b0);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5000) @(posedge clock);
    n_mismatch++;
    test_done();
  end
  initial begin
    n_mismatch = 0;
    cmp_count = 0;
    rstn = 1'b0;
    req_valid = 1'b0;
    req_write = 1'b0;
    req_bank = 2'h0;
    req_row = 12'h000;
    req_col = 8'h00;
    req_wdata = 16'h0000;
    req_mask = 2'h0;
    ref_req = 1'b0;
    repeat (6) @(posedge clock);
    rstn <= 1'b1;
    for (i = 0; i < 100 && init_done !== 1'b1; i++) @(posedge clock);
    check("init done", init_done, 1'b1);
    for (i = 0; i < 4; i++) access(1'b1, 2'(i), 12'hfff - 12'(i), 8'hfc + 8'(i),
                                   16'h1111 * 16'(i + 1), 2'h0);
    for (i = 0; i < 4; i++) access(1'b0, 2'(i), 12'hfff - 12'(i), 8'hfc + 8'(i),
                                   16'h0000, 2'h0);
    access(1'b1, 2'h0, 12'h001, 8'h01, 16'h1234, 2'h0);
    for (i = 1; i < 4; i++) begin
      access(1'b1, 2'h0, 12'h001, 8'h01, 16'habcd ^ 16'(i), 2'(i));
      access(1'b0, 2'h0, 12'h001, 8'h01, 16'h0000, 2'h0);
    end
    @(posedge clock);
    ref_req <= 1'b1;
    @(posedge clock);
    ref_req <= 1'b0;
    #1;
    check("ref pend", ref_pend, 1'b1);
    for (i = 0; i < 20 && wcmd !== CMD_REF; i++) @(posedge clock);
    check("ref issued", wcmd, CMD_REF);
    access(1'b0, 2'h2, 12'hffd, 8'hfe, 16'h0000, 2'h0);
    access(1'b1, 2'h3, 12'h000, 8'h00, 16'hc3c3, 2'h0);
    access(1'b0, 2'h3, 12'h000, 8'h00, 16'h0000, 2'h0);
    test_done();
  end
endmodule
`default_nettype wire
